// File: rtl/prm_consts.svh
/*
 power reduction mode controller constants: mode encodings, field positions, counts.
 assumes inclusion by bare name from rtl files.
*/
`ifndef PRM_CONSTS_SVH
`define PRM_CONSTS_SVH
`define PRM_MODE_LSB 0
`define PRM_MODE_MSB 1
`define PRM_MODE_RST 2'h0
`define PRM_MODE_NORMAL 2'h0
`define PRM_MODE_IDLE 2'h1
`define PRM_MODE_PD 2'h2
`define PRM_MODE_TPD 2'h3
`define PRM_XTAL_CLKS 1024
`define PRM_RC_CLKS 256
`define PRM_CNT_W 11
`endif

// File: rtl/prm_pkg.sv
/*
 types for the power reduction mode controller.
 assumes prm_consts.svh for widths.
*/
`include "prm_consts.svh"
package prm_pkg;
    // gray codes along run -> sleep -> wake; wake -> run flips both bits
    typedef enum logic [1:0] {
        PRM_RUN = 2'h0,
        PRM_SLEEP = 2'h1,
        PRM_WAKE = 2'h3,
        PRM_RSV = 2'h2
    } prm_state_t;
endpackage

// File: rtl/prm_stab_cnt.sv
/*
 oscillator stability counter: counts clocks after restart, flags done.
 assumes start pulse while idle; length chosen by crystal select.
*/
`timescale 1ns/1ns
`include "prm_consts.svh"
module prm_stab_cnt (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // control
    input wire logic start,
    input wire logic xtal_sel,
    // status
    output logic done
);
    logic [`PRM_CNT_W-1:0] cnt_r;
    logic [`PRM_CNT_W-1:0] cnt_nxt;
    logic done_nxt;
    logic [`PRM_CNT_W-1:0] limit;

    // crystals need longer to settle than rc or external clock
    assign limit = xtal_sel ? `PRM_CNT_W'(`PRM_XTAL_CLKS) : `PRM_CNT_W'(`PRM_RC_CLKS);

    // count from restart; done is one-cycle pulse at the limit
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (start) begin
            cnt_nxt = `PRM_CNT_W'(1);
        end else if (cnt_r != '0) begin
            if (cnt_r == limit) begin
                cnt_nxt = '0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + `PRM_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done <= done_nxt;
        end
    end
endmodule

// File: rtl/prm_ctrl.sv
/*
 power reduction mode controller: mode selection, oscillator gating,
 wake source qualification, restart after stability count.
 assumes synchronous inputs on mclk; the core writes the mode field with a strobe.
*/
`timescale 1ns/1ns
`include "prm_consts.svh"
module prm_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // control register write from the core
    input wire logic pcr_wr,
    input wire logic [7:0] power_control_reg,
    // enables
    input wire logic global_interrupt_enable,
    input wire logic bod_int_en,
    input wire logic kbd_int_en,
    input wire logic rtc_int_en,
    input wire logic wdt_int_en,
    input wire logic cmp_int_en,
    input wire logic [1:0] wake_int_en_idle_other,
    input wire logic wdt_rst_en,
    input wire logic bod_rst_en,
    // interrupt and reset requests
    input wire logic bod_int,
    input wire logic kbd_int,
    input wire logic rtc_int,
    input wire logic wdt_int,
    input wire logic cmp_int,
    input wire logic [1:0] other_int,
    input wire logic wdt_rst,
    input wire logic bod_rst,
    input wire logic ext_rst,
    // configuration
    input wire logic xtal_sel,
    input wire logic rc_is_sysclk,
    input wire logic rtc_en,
    input wire logic watchdog_clock_select,
    input wire logic rtc_power_down,
    input wire logic cmp_pd,
    input wire logic cmp_en,
    // outputs
    output logic [1:0] power_mode_select,
    output logic cpu_run,
    output logic periph_clk_en,
    output logic main_osc_en,
    output logic rc_osc_en,
    output logic bod_en,
    output logic cmp_pwr_en,
    output logic wdt_keep,
    output logic rtc_keep,
    output logic wake_pulse
);
    prm_pkg::prm_state_t st_r;
    prm_pkg::prm_state_t st_nxt;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic osc_start_r;
    logic osc_start_nxt;
    logic stab_done;
    logic wake_int_idle;
    logic wake_pd;
    logic any_rst;
    logic wake_nxt;

    // mode field decode, used more than once
    function automatic logic is_pd(input logic [1:0] m);
        is_pd = (m == `PRM_MODE_PD) || (m == `PRM_MODE_TPD);
    endfunction

    function automatic logic is_tpd(input logic [1:0] m);
        is_tpd = (m == `PRM_MODE_TPD);
    endfunction

    // a reset only counts when its source is enabled; pin reset always enabled
    assign any_rst = ext_rst | (wdt_rst & wdt_rst_en) | (bod_rst & bod_rst_en);

    // idle: any enabled interrupt under the global enable
    assign wake_int_idle = global_interrupt_enable & ((bod_int & bod_int_en)
        | (kbd_int & kbd_int_en) | (rtc_int & rtc_int_en) | (wdt_int & wdt_int_en)
        | (cmp_int & cmp_int_en) | (|(other_int & wake_int_en_idle_other)));

    // power-down wake sources; tpd drops brownout and comparator and needs wdt clock
    always_comb begin
        wake_pd = 1'b0;
        if (global_interrupt_enable) begin
            wake_pd = (kbd_int & kbd_int_en) | (rtc_int & rtc_int_en);
            if (!is_tpd(mode_r)) begin
                wake_pd = wake_pd | (bod_int & bod_int_en) | (cmp_int & cmp_int_en)
                    | (wdt_int & wdt_int_en);
            end else begin
                wake_pd = wake_pd | (wdt_int & wdt_int_en & watchdog_clock_select);
            end
        end
        if (is_tpd(mode_r)) begin
            wake_pd = wake_pd | ext_rst | (wdt_rst & wdt_rst_en & watchdog_clock_select);
        end else begin
            wake_pd = wake_pd | any_rst;
        end
    end

    // state and mode next values
    always_comb begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        osc_start_nxt = 1'b0;
        wake_nxt = 1'b0;
        case (st_r)
            prm_pkg::PRM_RUN: begin
                if (pcr_wr) begin
                    mode_nxt = power_control_reg[`PRM_MODE_MSB:`PRM_MODE_LSB];
                    if (mode_nxt != `PRM_MODE_NORMAL) begin
                        st_nxt = prm_pkg::PRM_SLEEP;
                    end
                end
            end
            prm_pkg::PRM_SLEEP: begin
                if (!is_pd(mode_r)) begin
                    if (wake_int_idle | any_rst) begin
                        mode_nxt = `PRM_MODE_NORMAL;
                        st_nxt = prm_pkg::PRM_RUN;
                        wake_nxt = 1'b1;
                    end
                end else if (wake_pd) begin
                    osc_start_nxt = 1'b1;
                    st_nxt = prm_pkg::PRM_WAKE;
                end
            end
            prm_pkg::PRM_WAKE: begin
                if (stab_done) begin
                    mode_nxt = `PRM_MODE_NORMAL;
                    st_nxt = prm_pkg::PRM_RUN;
                    wake_nxt = 1'b1;
                end
            end
            default: begin
                st_nxt = prm_pkg::PRM_RUN;
                mode_nxt = `PRM_MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= prm_pkg::PRM_RUN;
            mode_r <= `PRM_MODE_RST;
            osc_start_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            osc_start_r <= osc_start_nxt;
        end
    end

    // stability timer, started as the oscillator restarts
    prm_stab_cnt u_stab (
        .mclk(mclk),
        .rst_b(rst_b),
        .start(osc_start_r),
        .xtal_sel(xtal_sel),
        .done(stab_done)
    );

    // output next values from next state so outputs are registered and in step
    logic cpu_run_nxt;
    logic periph_nxt;
    logic main_osc_nxt;
    logic rc_osc_nxt;
    logic bod_en_nxt;
    logic cmp_pwr_nxt;
    logic wdt_keep_nxt;
    logic rtc_keep_nxt;
    logic sleeping_pd;

    always_comb begin
        sleeping_pd = (st_nxt == prm_pkg::PRM_SLEEP) && is_pd(mode_nxt);
        cpu_run_nxt = (st_nxt == prm_pkg::PRM_RUN);
        periph_nxt = !sleeping_pd && (st_nxt != prm_pkg::PRM_WAKE);
        main_osc_nxt = !sleeping_pd;
        rc_osc_nxt = !sleeping_pd || (rc_is_sysclk && rtc_en);
        bod_en_nxt = !(sleeping_pd && is_tpd(mode_nxt));
        cmp_pwr_nxt = bod_en_nxt && !(sleeping_pd && cmp_pd && !cmp_en);
        wdt_keep_nxt = !sleeping_pd || watchdog_clock_select;
        rtc_keep_nxt = !sleeping_pd || !rtc_power_down;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            power_mode_select <= `PRM_MODE_RST;
            cpu_run <= 1'b1;
            periph_clk_en <= 1'b1;
            main_osc_en <= 1'b1;
            rc_osc_en <= 1'b1;
            bod_en <= 1'b1;
            cmp_pwr_en <= 1'b1;
            wdt_keep <= 1'b1;
            rtc_keep <= 1'b1;
            wake_pulse <= 1'b0;
        end else begin
            power_mode_select <= mode_nxt;
            cpu_run <= cpu_run_nxt;
            periph_clk_en <= periph_nxt;
            main_osc_en <= main_osc_nxt;
            rc_osc_en <= rc_osc_nxt;
            bod_en <= bod_en_nxt;
            cmp_pwr_en <= cmp_pwr_nxt;
            wdt_keep <= wdt_keep_nxt;
            rtc_keep <= rtc_keep_nxt;
            wake_pulse <= wake_nxt;
        end
    end

    // checks
    sequence s_pd_wake;
        (st_r == prm_pkg::PRM_SLEEP) && is_pd(mode_r) && wake_pd;
    endsequence

    sequence s_restart;
        ##2 main_osc_en && !cpu_run;
    endsequence

    chk_reset_normal: assert property (@(posedge mclk) $rose(rst_b) |-> mode_r == 2'h0)
        else $error("mode not normal after reset");
    // a wake seen in this cycle rightly lets the cpu run again at the next edge
    chk_idle_halt: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && mode_r == 2'h1 && !(wake_int_idle || any_rst))
        |=> (!cpu_run && periph_clk_en))
        else $error("idle did not halt cpu with peripherals on");
    chk_idle_exit: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && mode_r == 2'h1 && (wake_int_idle || any_rst))
        |=> (cpu_run && wake_pulse))
        else $error("idle did not end on wake");
    chk_pd_osc_off: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && is_pd(mode_r) && !wake_pd) |=> !main_osc_en)
        else $error("oscillator running in power-down");
    chk_pd_restart: assert property (@(posedge mclk) disable iff (!rst_b)
        s_pd_wake |-> s_restart)
        else $error("oscillator not restarted on wake");
    chk_stab_bound: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_pd_wake and (xtal_sel == 1'b0)) ##1 (!xtal_sel) [*8] |-> !cpu_run)
        else $error("cpu ran before stability count");
    chk_stab_run: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_WAKE && !xtal_sel) |-> ##[1:258] cpu_run)
        else $error("cpu not resumed after rc count");
    chk_rc_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && is_pd(mode_r) && !wake_pd && !(rc_is_sysclk && rtc_en))
        |=> !rc_osc_en)
        else $error("rc oscillator left on in power-down");
    chk_tpd_bod_off: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && mode_r == 2'h3 && !wake_pd) |=> (!bod_en && !cmp_pwr_en))
        else $error("brownout or comparator on in total power-down");
    chk_tpd_no_bod_wake: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && mode_r == 2'h3 && !ext_rst && !kbd_int && !rtc_int
        && !wdt_int && !wdt_rst) |=> st_r == prm_pkg::PRM_SLEEP)
        else $error("total power-down woke on excluded source");
    chk_wake_gated: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && is_pd(mode_r) && !global_interrupt_enable && !ext_rst
        && !wdt_rst && !bod_rst) |=> st_r == prm_pkg::PRM_SLEEP)
        else $error("woke without global enable");
    chk_mode_field: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_RUN && pcr_wr) |=> power_mode_select == $past(power_control_reg[1:0]))
        else $error("mode field not taken from bits 1 to 0");
    chk_pd_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && mode_r == 2'h2 && !wake_pd) |=> (bod_en
        && (wdt_keep == $past(watchdog_clock_select))))
        else $error("power-down keep set wrong");
    // wake path: oscillator up and cpu held, bounded crystal count, single pulse
    chk_wake_osc_on: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_WAKE) |-> (main_osc_en && !cpu_run))
        else $error("oscillator off or cpu running while waiting for stability");
    chk_stab_xtal: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_WAKE && xtal_sel) |-> ##[1:1026] cpu_run)
        else $error("cpu not resumed after crystal count");
    chk_wake_pulse_one: assert property (@(posedge mclk) disable iff (!rst_b)
        wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    chk_pd_mode_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && is_pd(mode_r) && !wake_pd)
        |=> $stable(power_mode_select))
        else $error("mode field changed while asleep");
    chk_rc_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        (rc_is_sysclk && rtc_en) |=> rc_osc_en)
        else $error("rc oscillator stopped while clocking the rtc");
    chk_tpd_wdt_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_r == prm_pkg::PRM_SLEEP && mode_r == 2'h3 && !watchdog_clock_select && !ext_rst
        && !kbd_int && !rtc_int) |=> st_r == prm_pkg::PRM_SLEEP)
        else $error("total power-down woke on unclocked watchdog");
endmodule

// File: tb/prm_src_model.sv
/*
 model of the wake capable sources: one request line held until the wake.
 assumes fire, clr and sel come from the bench on mclk.
*/
`timescale 1ns/1ns
module prm_src_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // control from the bench
    input wire logic fire,
    input wire logic clr,
    input wire logic [3:0] sel,
    // wake seen
    input wire logic wake_pulse,
    // requests
    output logic [9:0] req
);
    logic [9:0] req_nxt;
    // level sources keep asking until serviced, so a late wake still sees them
    always_comb begin
        req_nxt = req;
        if (wake_pulse || clr) begin
            req_nxt = 10'h000;
        end
        if (fire) begin
            req_nxt = 10'h001 << sel;
        end
    end
    // request register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            req <= 10'h000;
        end else begin
            req <= req_nxt;
        end
    end
endmodule

// File: tb/testbench.sv
/*
 self-checking bench for the power reduction mode controller.
 assumes prm_ctrl and prm_src_model; all inputs driven on mclk rising edge.
*/
`timescale 1ns/1ns
`include "prm_consts.svh"
module testbench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic pcr_wr = 1'b0;
    logic [7:0] pcr = 8'h00;
    logic gie = 1'b0;
    logic [8:0] en = 9'h000;
    logic [6:0] cfg = 7'h00;
    logic fire = 1'b0;
    logic clr = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [9:0] req;
    logic [1:0] mode;
    logic cpu_run, periph_clk_en, main_osc_en, rc_osc_en, bod_en, cmp_pwr_en;
    logic wdt_keep, rtc_keep, wake_pulse;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int pulses = 0;
    int n;
    prm_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .pcr_wr(pcr_wr), .power_control_reg(pcr),
        .global_interrupt_enable(gie), .bod_int_en(en[0]), .kbd_int_en(en[1]),
        .rtc_int_en(en[2]), .wdt_int_en(en[3]), .cmp_int_en(en[4]),
        .wake_int_en_idle_other(en[6:5]), .wdt_rst_en(en[7]), .bod_rst_en(en[8]),
        .bod_int(req[0]), .kbd_int(req[1]), .rtc_int(req[2]), .wdt_int(req[3]),
        .cmp_int(req[4]), .other_int(req[6:5]), .wdt_rst(req[7]), .bod_rst(req[8]),
        .ext_rst(req[9]), .xtal_sel(cfg[0]), .rc_is_sysclk(cfg[1]), .rtc_en(cfg[2]),
        .watchdog_clock_select(cfg[3]), .rtc_power_down(cfg[4]), .cmp_pd(cfg[5]),
        .cmp_en(cfg[6]), .power_mode_select(mode), .cpu_run(cpu_run),
        .periph_clk_en(periph_clk_en), .main_osc_en(main_osc_en), .rc_osc_en(rc_osc_en),
        .bod_en(bod_en), .cmp_pwr_en(cmp_pwr_en), .wdt_keep(wdt_keep),
        .rtc_keep(rtc_keep), .wake_pulse(wake_pulse));
    prm_src_model u_src (.mclk(mclk), .rst_b(rst_b), .fire(fire), .clr(clr), .sel(sel),
        .wake_pulse(wake_pulse), .req(req));
    // clock, wake pulse count and hang guard
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (wake_pulse === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // one write strobe, then let the new mode settle
    task automatic set_mode(input logic [7:0] v);
        @(posedge mclk);
        pcr_wr <= 1'b1;
        pcr <= v;
        @(posedge mclk);
        pcr_wr <= 1'b0;
        tick(2);
    endtask
    // raise one source (c=0) or drop every source (c=1)
    task automatic src(input logic [3:0] s, input logic c);
        @(posedge mclk);
        fire <= !c;
        clr <= c;
        sel <= s;
        @(posedge mclk);
        fire <= 1'b0;
        clr <= 1'b0;
        #1;
    endtask
    // bounded wait for execution to resume
    task automatic wait_run(output int k);
        k = 0;
        while (cpu_run !== 1'b1 && k < 2000) begin
            tick(1);
            k = k + 1;
        end
    endtask
    task automatic t_reset();
        chk("mode after reset", mode, 2'h0);
        chk("run after reset", cpu_run, 1'b1);
        set_mode(8'hFC);
        chk("normal write", {mode, cpu_run}, 3'h1);
    endtask
    task automatic t_idle();
        @(posedge mclk);
        en <= 9'h002;
        gie <= 1'b0;
        set_mode(8'hFD);
        chk("idle mode", mode, 2'h1);
        chk("idle run periph", {cpu_run, periph_clk_en}, 2'h1);
        src(4'h1, 1'b0);
        tick(5);
        chk("masked idle wake", cpu_run, 1'b0);
        @(posedge mclk);
        gie <= 1'b1;
        tick(3);
        chk("idle wake", {mode, cpu_run}, 3'h1);
        chk("wake pulses", pulses, 1);
    endtask
    // power-down entry, outputs from config, wake by source s, stability count
    task automatic t_pd(input logic [6:0] c, input logic [3:0] s);
        int cnt;
        cnt = c[0] ? `PRM_XTAL_CLKS : `PRM_RC_CLKS;
        @(posedge mclk);
        cfg <= c;
        set_mode(8'h02);
        chk("pd osc run periph", {main_osc_en, cpu_run, periph_clk_en}, 3'h0);
        chk("pd rc osc", rc_osc_en, c[1] & c[2]);
        chk("pd keep", {bod_en, wdt_keep, rtc_keep}, {1'b1, c[3], !c[4]});
        chk("pd cmp", cmp_pwr_en, !(c[5] & !c[6]));
        src(s, 1'b0);
        tick(2);
        chk("restart osc", {main_osc_en, cpu_run}, 2'h2);
        wait_run(n);
        chk("stable count", n >= cnt && n <= cnt + 4, 1'b1);
        chk("pd wake mode", mode, 2'h0);
    endtask
    task automatic t_tpd();
        @(posedge mclk);
        cfg <= 7'h26;
        set_mode(8'h03);
        chk("tpd mode", mode, 2'h3);
        chk("tpd bod cmp", {bod_en, cmp_pwr_en, main_osc_en}, 3'h0);
        chk("tpd rc osc", rc_osc_en, 1'b1);
        for (int s = 0; s < 9; s += 4) begin
            src(s[3:0], 1'b0);
            tick(5);
            chk("tpd ignored wake", cpu_run, 1'b0);
            src(4'h0, 1'b1);
        end
        src(4'h3, 1'b0);
        tick(5);
        chk("wdt wake without clock", cpu_run, 1'b0);
        @(posedge mclk);
        cfg <= 7'h2E;
        wait_run(n);
        chk("wdt wake", cpu_run, 1'b1);
        set_mode(8'h03);
        src(4'h1, 1'b0);
        wait_run(n);
        chk("kbd wake", {mode, cpu_run}, 3'h1);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        tick(1);
        t_reset();
        t_idle();
        @(posedge mclk);
        en <= 9'h1FF;
        for (int s = 0; s < 5; s++) begin
            t_pd(7'h2E, s[3:0]);
        end
        // wake by reset with interrupts globally off
        @(posedge mclk);
        gie <= 1'b0;
        t_pd(7'h55, 4'h9);
        @(posedge mclk);
        gie <= 1'b1;
        t_tpd();
        // one pulse per return to run: idle, five pd, reset pd, two tpd
        tick(1);
        chk("all wake pulses", pulses, 9);
        end_sim();
    end
endmodule
